// ---- rtl/i2csc_map.vh ----
// Purpose: Offsets, field positions, reset values and counts for the I2C status/divider block
// Assumes: 32-bit word registers at byte offsets
// Notes: Control register offset chosen locally; no offset is printed for it
`ifndef I2CSC_MAP_VH
`define I2CSC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define I2CSC_OFS_CTRL 8'h00
`define I2CSC_OFS_STAT 8'h04
`define I2CSC_OFS_DIV 8'h08
`define I2CSC_OFS_GLT 8'h14

// ----------------------------------------
// Control bits
// ----------------------------------------
`define I2CSC_CTL_SRST 0
`define I2CSC_CTL_EN 1
`define I2CSC_CTL_SCLEN 2
`define I2CSC_CTL_TXIE 8
`define I2CSC_CTL_RXIE 9
`define I2CSC_CTL_NACKIE 10
`define I2CSC_CTL_STOPIE 11
`define I2CSC_CTL_ADDRIE 12
`define I2CSC_CTL_ARBIE 13
`define I2CSC_CTL_STARTIE 14
`define I2CSC_CTL_WMASK 32'h00007f07

// ----------------------------------------
// Status bits
// ----------------------------------------
`define I2CSC_ST_DIR 0
`define I2CSC_ST_ACK 1
`define I2CSC_ST_CBUSY 2
`define I2CSC_ST_FBUSY 3
`define I2CSC_ST_TXD 4
`define I2CSC_ST_RXD 5
`define I2CSC_ST_NACKERR 6
`define I2CSC_ST_STOP 7
`define I2CSC_ST_OWNADDR 8
`define I2CSC_ST_GCALL 9
`define I2CSC_ST_ARBLOST 10
`define I2CSC_ST_START 11
`define I2CSC_ST_DEFADDR 20

// ----------------------------------------
// Widths, resets, counts
// ----------------------------------------
`define I2CSC_DIV_W 18
`define I2CSC_GLT_LSB 10
`define I2CSC_GLT_W 4
`define I2CSC_RST_CR 32'h00000000
`define I2CSC_RST_DIV 18'h00000
`define I2CSC_SRST_CYC 2'h2

`endif

// ---- rtl/i2csc_core.v ----
// Purpose: Enable and soft reset, event status flags with read-to-clear, IRQ, SCL divider
// Assumes: Register port is a simple synchronous strobe interface; events are one-cycle pulses
// Notes: Glitch length adds its extra cycles to one SCL half period per full period
`timescale 1ns/1ps
`include "i2csc_map.vh"

module i2csc_core
(
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Register access
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    output reg [31:0] REG_RDATA,
    // Bus events, one-cycle pulses
    input wire EV_DEFAULT_ADDR,
    input wire EV_START,
    input wire EV_ARB_LOST,
    input wire EV_GENERAL_CALL,
    input wire EV_OWN_ADDR,
    input wire EV_STOP,
    input wire EV_SLAVE_NACK,
    input wire EV_RX_BYTE,
    input wire EV_TX_BYTE,
    // Bus state levels
    input wire IS_MASTER,
    input wire IS_SLAVE,
    input wire IS_RECEIVER,
    input wire BUS_BUSY,
    input wire OWN_START,
    input wire NACK_SEEN,
    // Outputs
    output reg IRQ,
    output reg CTRL_ENABLE,
    output reg CTRL_RESET,
    output reg SCL_DRIVE,
    output reg [3:0] GLITCH_LEN
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [31:0] ctrl_q;
reg [1:0] srst_cnt_q;
reg [17:0] div_q;
reg [3:0] glt_q;
reg [17:0] cnt_q;
reg [3:0] ext_q;
reg ext_done_q;
reg scl_q;
reg ev_defa_q, ev_start_q, ev_arb_q, ev_gcall_q, ev_own_q;
reg ev_stop_q, ev_nack_q, ev_rxd_q, ev_txd_q;
reg cbusy_q, ack_q;
reg [31:0] stat_w;
reg [31:0] rdata_d;
wire run;
wire rd_stat;
wire wr_ctrl;
wire soft_rst;

// Flag update: set wins over read clear
function next_flag;
    input cur;
    input set;
    input clr;
    begin
        next_flag = set | (cur & ~clr);
    end
endfunction

function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
        sel = (a == ofs);
    end
endfunction

assign wr_ctrl = REG_WR & sel(REG_ADDR, `I2CSC_OFS_CTRL);
assign rd_stat = REG_RD & sel(REG_ADDR, `I2CSC_OFS_STAT);
assign soft_rst = ctrl_q[`I2CSC_CTL_SRST];
assign run = ctrl_q[`I2CSC_CTL_EN] & ~soft_rst;

// ----------------------------------------
// Control and configuration
// ----------------------------------------
always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        ctrl_q <= `I2CSC_RST_CR;
        srst_cnt_q <= 2'h0;
        div_q <= `I2CSC_RST_DIV;
        glt_q <= 4'h0;
    end
    else
    begin
        if (wr_ctrl)
        begin
            ctrl_q <= REG_WDATA & `I2CSC_CTL_WMASK;
            srst_cnt_q <= 2'h0;
        end
        else if (soft_rst)
        begin
            // Self-clear after two clocks
            if (srst_cnt_q == `I2CSC_SRST_CYC - 2'h1)
            begin
                ctrl_q[`I2CSC_CTL_SRST] <= 1'b0;
                srst_cnt_q <= 2'h0;
            end
            else
            begin
                srst_cnt_q <= srst_cnt_q + 2'h1;
            end
        end
        if (REG_WR & sel(REG_ADDR, `I2CSC_OFS_DIV))
        begin
            div_q <= REG_WDATA[`I2CSC_DIV_W-1:0];
        end
        if (REG_WR & sel(REG_ADDR, `I2CSC_OFS_GLT))
        begin
            glt_q <= REG_WDATA[`I2CSC_GLT_LSB+`I2CSC_GLT_W-1:`I2CSC_GLT_LSB];
        end
    end
end

// ----------------------------------------
// Event flags
// ----------------------------------------
always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        ev_defa_q <= 1'b0;
        ev_start_q <= 1'b0;
        ev_arb_q <= 1'b0;
        ev_gcall_q <= 1'b0;
        ev_own_q <= 1'b0;
        ev_stop_q <= 1'b0;
        ev_nack_q <= 1'b0;
        ev_rxd_q <= 1'b0;
        ev_txd_q <= 1'b0;
        cbusy_q <= 1'b0;
        ack_q <= 1'b0;
    end
    else if (soft_rst)
    begin
        // Soft reset wipes controller state
        ev_defa_q <= 1'b0;
        ev_start_q <= 1'b0;
        ev_arb_q <= 1'b0;
        ev_gcall_q <= 1'b0;
        ev_own_q <= 1'b0;
        ev_stop_q <= 1'b0;
        ev_nack_q <= 1'b0;
        ev_rxd_q <= 1'b0;
        ev_txd_q <= 1'b0;
        cbusy_q <= 1'b0;
        ack_q <= 1'b0;
    end
    else
    begin
        ev_defa_q <= next_flag(ev_defa_q, run & EV_DEFAULT_ADDR, rd_stat);
        ev_start_q <= next_flag(ev_start_q, run & EV_START, rd_stat);
        ev_arb_q <= next_flag(ev_arb_q, run & IS_MASTER & EV_ARB_LOST, rd_stat);
        ev_gcall_q <= next_flag(ev_gcall_q, run & IS_SLAVE & EV_GENERAL_CALL, rd_stat);
        ev_own_q <= next_flag(ev_own_q, run & IS_SLAVE & EV_OWN_ADDR, rd_stat);
        ev_stop_q <= next_flag(ev_stop_q, run & EV_STOP, rd_stat);
        ev_nack_q <= next_flag(ev_nack_q, run & IS_MASTER & EV_SLAVE_NACK, rd_stat);
        ev_rxd_q <= next_flag(ev_rxd_q, run & EV_RX_BYTE, rd_stat);
        ev_txd_q <= next_flag(ev_txd_q, run & EV_TX_BYTE, rd_stat);
        // Own transaction window: own start until next stop
        if (run & OWN_START)
        begin
            cbusy_q <= 1'b1;
        end
        else if (EV_STOP | ~run)
        begin
            cbusy_q <= 1'b0;
        end
        // Not-acknowledge status follows the last acknowledge slot
        if (run & NACK_SEEN)
        begin
            ack_q <= 1'b1;
        end
        else if (run & (EV_RX_BYTE | EV_TX_BYTE | EV_START))
        begin
            ack_q <= 1'b0;
        end
    end
end

// ----------------------------------------
// Status word and read data
// ----------------------------------------
always @*
begin
    stat_w = 32'h00000000;
    stat_w[`I2CSC_ST_DEFADDR] = ev_defa_q;
    stat_w[`I2CSC_ST_START] = ev_start_q;
    stat_w[`I2CSC_ST_ARBLOST] = ev_arb_q;
    stat_w[`I2CSC_ST_GCALL] = ev_gcall_q;
    stat_w[`I2CSC_ST_OWNADDR] = ev_own_q;
    stat_w[`I2CSC_ST_STOP] = ev_stop_q;
    stat_w[`I2CSC_ST_NACKERR] = ev_nack_q;
    stat_w[`I2CSC_ST_RXD] = ev_rxd_q;
    stat_w[`I2CSC_ST_TXD] = ev_txd_q;
    stat_w[`I2CSC_ST_FBUSY] = run & BUS_BUSY & ~cbusy_q;
    stat_w[`I2CSC_ST_CBUSY] = cbusy_q;
    stat_w[`I2CSC_ST_ACK] = ack_q;
    stat_w[`I2CSC_ST_DIR] = run & ((IS_MASTER & IS_RECEIVER) | (IS_SLAVE & ~IS_RECEIVER));
    rdata_d = 32'h00000000;
    case (REG_ADDR)
        `I2CSC_OFS_CTRL: rdata_d = ctrl_q;
        `I2CSC_OFS_STAT: rdata_d = stat_w;
        `I2CSC_OFS_DIV: rdata_d = {14'h0000, div_q};
        `I2CSC_OFS_GLT: rdata_d = {18'h00000, glt_q, 10'h000};
        default: rdata_d = 32'h00000000;
    endcase
end

// ----------------------------------------
// SCL divider
// ----------------------------------------
// Extra glitch cycles are spent once per period, on the low half
always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        cnt_q <= `I2CSC_RST_DIV;
        ext_q <= 4'h0;
        ext_done_q <= 1'b0;
        scl_q <= 1'b1;
    end
    else if (~(run & ctrl_q[`I2CSC_CTL_SCLEN]))
    begin
        cnt_q <= div_q;
        ext_q <= glt_q;
        ext_done_q <= 1'b0;
        scl_q <= 1'b1;
    end
    else if (cnt_q != 18'h00000)
    begin
        cnt_q <= cnt_q - 18'h00001;
    end
    else if (~scl_q & ~ext_done_q & (ext_q != 4'h0))
    begin
        ext_q <= ext_q - 4'h1;
        if (ext_q == 4'h1)
        begin
            ext_done_q <= 1'b1;
        end
    end
    else
    begin
        // Zero plus one reload cycle gives divider+2 per half period
        cnt_q <= div_q + 18'h00001;
        scl_q <= ~scl_q;
        ext_q <= glt_q;
        ext_done_q <= 1'b0;
    end
end

// ----------------------------------------
// Registered outputs
// ----------------------------------------
always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        REG_RDATA <= 32'h00000000;
        IRQ <= 1'b0;
        CTRL_ENABLE <= 1'b0;
        CTRL_RESET <= 1'b0;
        SCL_DRIVE <= 1'b1;
        GLITCH_LEN <= 4'h0;
    end
    else
    begin
        REG_RDATA <= REG_RD ? rdata_d : 32'h00000000;
        IRQ <= (ev_start_q & ctrl_q[`I2CSC_CTL_STARTIE])
             | (ev_arb_q & ctrl_q[`I2CSC_CTL_ARBIE])
             | ((ev_own_q | ev_gcall_q | ev_defa_q) & ctrl_q[`I2CSC_CTL_ADDRIE])
             | (ev_stop_q & ctrl_q[`I2CSC_CTL_STOPIE])
             | (ev_nack_q & ctrl_q[`I2CSC_CTL_NACKIE])
             | (ev_rxd_q & ctrl_q[`I2CSC_CTL_RXIE])
             | (ev_txd_q & ctrl_q[`I2CSC_CTL_TXIE]);
        CTRL_ENABLE <= run;
        CTRL_RESET <= soft_rst;
        SCL_DRIVE <= scl_q;
        GLITCH_LEN <= glt_q;
    end
end

endmodule

// ---- bench/i2csc_monitor.sv ----
// Purpose: Port checks for the status/divider block
// Assumes: Control at 8'h00, divider 8'h08, glitch field 8'h14
// Notes: SCL halves judged from second toggle on
`timescale 1ns/1ps
module i2csc_monitor
(
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Register port
    input wire REG_WR,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    // Observed
    input wire EV_START,
    input wire IRQ,
    input wire CTRL_ENABLE,
    input wire CTRL_RESET,
    input wire SCL_DRIVE,
    input wire [3:0] GLITCH_LEN
);
    reg [31:0] ctrl_q;
    reg [17:0] div_q;
    reg scl_p_q;
    reg tv_q;
    reg [19:0] hc_q;
    wire chg = SCL_DRIVE != scl_p_q;
    wire cw = REG_WR && REG_ADDR == 8'h00;
    // First half after enable is short, so it is never measured
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_q <= 32'h0;
            div_q <= 18'h0;
            scl_p_q <= 1'b1;
            tv_q <= 1'b0;
            hc_q <= 20'h0;
        end
        else
        begin
            if (cw)
                ctrl_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h08)
                div_q <= REG_WDATA[17:0];
            scl_p_q <= SCL_DRIVE;
            hc_q <= chg ? 20'h1 : hc_q + 20'h1;
            tv_q <= (REG_WR || CTRL_RESET || !ctrl_q[2] || !ctrl_q[1]) ? 1'b0 : (chg | tv_q);
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_tog;
        chg && tv_q;
    endsequence
    sequence s_srst_wr;
        cw && REG_WDATA[0];
    endsequence
    property p_half(lvl, extra);
        s_tog ##0 (SCL_DRIVE == lvl) |-> hc_q == {2'h0, div_q} + 20'h2 + extra;
    endproperty
    a_scl_high: assert property (p_half(1'b0, 20'h0))
        else $error("SCL high half wrong length");
    a_scl_low: assert property (p_half(1'b1, {16'h0, GLITCH_LEN}))
        else $error("SCL low half wrong length");
    a_srst_pulse: assert property (s_srst_wr |-> ##[1:2] CTRL_RESET ##[1:3] !CTRL_RESET)
        else $error("soft reset pulse wrong");
    a_srst_dis: assert property ($rose(CTRL_RESET) |-> ##[0:1] !CTRL_ENABLE)
        else $error("enable kept during soft reset");
    a_en_off: assert property (cw && !REG_WDATA[1] |-> ##[1:2] !CTRL_ENABLE)
        else $error("enable not dropped");
    a_en_on: assert property (cw && REG_WDATA[1:0] == 2'h2 |-> ##[1:2] CTRL_ENABLE)
        else $error("enable not raised");
    a_irq_start: assert property (EV_START && ctrl_q[14] && ctrl_q[1] && !CTRL_RESET
        |-> ##[1:2] IRQ)
        else $error("start event gave no irq");
    a_glitch_load: assert property (REG_WR && REG_ADDR == 8'h14
        |-> ##2 GLITCH_LEN == $past(REG_WDATA[13:10], 2))
        else $error("glitch field not loaded");
endmodule
bind i2csc_core i2csc_monitor mon_u (.CLK(CLK), .RST(RST), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .EV_START(EV_START), .IRQ(IRQ),
    .CTRL_ENABLE(CTRL_ENABLE), .CTRL_RESET(CTRL_RESET), .SCL_DRIVE(SCL_DRIVE),
    .GLITCH_LEN(GLITCH_LEN));

// ---- bench/i2csc_eng.sv ----
// Purpose: Shift engine stand-in raising event pulses
// Assumes: Requests change just after a falling edge
// Notes: Pulses land one falling edge late, one cycle wide
`timescale 1ns/1ps
module i2csc_eng
(
    // Clock
    input wire clk,
    // Requests and pulses
    input wire [8:0] kick,
    output reg [8:0] ev
);
    initial ev = 9'h0;
    // No memory of old requests, so a pulse never stretches
    always @(negedge clk)
        ev <= kick;
endmodule

// ---- bench/i2c_status_and_clock_divider_tb.sv ----
// Purpose: Self-checking bench for the status/divider block
// Assumes: Inputs change at the falling edge
// Notes: Seeded xorshift picks levels, divider and glitch length
`timescale 1ns/1ps
module i2c_status_and_clock_divider_tb;
    localparam [31:0] M = 32'h00100ff0;
    reg CLK, RST, REG_WR, REG_RD, IS_MASTER, IS_SLAVE, IS_RECEIVER, BUS_BUSY;
    reg own_st, nack_p;
    reg [7:0] REG_ADDR;
    reg [31:0] REG_WDATA, v1, v2, seed;
    reg [8:0] kick;
    reg [17:0] d;
    reg [3:0] g;
    wire [31:0] REG_RDATA;
    wire [8:0] ev;
    wire IRQ, CTRL_ENABLE, CTRL_RESET, SCL_DRIVE;
    wire [3:0] GLITCH_LEN;
    integer num_errors, checked, cyc, i, n;
    i2csc_eng eng_u (.clk(CLK), .kick(kick), .ev(ev));
    i2csc_core dut_u (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .EV_DEFAULT_ADDR(ev[0]), .EV_START(ev[1]), .EV_ARB_LOST(ev[2]),
        .EV_GENERAL_CALL(ev[3]), .EV_OWN_ADDR(ev[4]), .EV_STOP(ev[5]),
        .EV_SLAVE_NACK(ev[6]), .EV_RX_BYTE(ev[7]), .EV_TX_BYTE(ev[8]),
        .IS_MASTER(IS_MASTER), .IS_SLAVE(IS_SLAVE), .IS_RECEIVER(IS_RECEIVER),
        .BUS_BUSY(BUS_BUSY), .OWN_START(own_st), .NACK_SEEN(nack_p), .IRQ(IRQ),
        .CTRL_ENABLE(CTRL_ENABLE), .CTRL_RESET(CTRL_RESET), .SCL_DRIVE(SCL_DRIVE),
        .GLITCH_LEN(GLITCH_LEN));
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function integer fpos(input integer k);
        fpos = (k == 0) ? 20 : 12 - k;
    endfunction
    function exp_dir(input m, input s, input r);
        exp_dir = (m & r) | (s & ~r);
    endfunction
    task end_sim;
    begin
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task cmp_w(input [31:0] got, input [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task cmp_b(input got, input exp);
        cmp_w({31'h0, got}, {31'h0, exp});
    endtask
    task idle(input integer k);
        repeat (k) @(negedge CLK);
    endtask
    task wr(input [7:0] a, input [31:0] w);
    begin
        @(negedge CLK);
        {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, w};
        @(negedge CLK);
        REG_WR = 1'b0;
    end
    endtask
    // Two reads back to back: v1 shows flags, v2 what survived the clear
    task rdb(input [7:0] a);
    begin
        @(negedge CLK);
        {REG_RD, REG_ADDR} = {1'b1, a};
        idle(1);
        v1 = REG_RDATA;
        idle(1);
        v2 = REG_RDATA;
        REG_RD = 1'b0;
    end
    endtask
    task pulse(input integer k);
    begin
        @(negedge CLK);
        kick <= 9'h1 << k;
        @(negedge CLK);
        kick <= 9'h0;
        idle(2);
    end
    endtask
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    initial
    begin
        {RST, REG_WR, REG_RD, IS_MASTER, IS_SLAVE, IS_RECEIVER, BUS_BUSY, own_st, nack_p} = 9'h100;
        {REG_ADDR, REG_WDATA, kick, cyc, num_errors, checked} = 0;
        seed = 32'h0548;
        repeat (3) @(posedge CLK);
        @(negedge CLK) RST = 1'b0;
        rdb(8'h00);
        cmp_w(v1, 32'h0);
        rdb(8'h04);
        cmp_w(v1, 32'h0);
        rdb(8'h08);
        cmp_w(v1, 32'h0);
        rdb(8'h20);
        cmp_w(v1, 32'h0);
        wr(8'h00, 32'h0);
        pulse(1);
        rdb(8'h04);
        cmp_w(v1 & M, 32'h0);
        wr(8'h00, 32'h7f02);
        for (i = 0; i < 9; i = i + 1)
        begin
            seed = xs(seed);
            {IS_MASTER, IS_SLAVE, IS_RECEIVER} = {i == 2 || i == 6, i == 3 || i == 4, seed[0]};
            pulse(i);
            cmp_b(IRQ, 1'b1);
            rdb(8'h04);
            cmp_w(v1 & M, 32'h1 << fpos(i));
            cmp_w(v2 & M, 32'h0);
            idle(2);
            cmp_b(IRQ, 1'b0);
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            seed = xs(seed);
            {IS_MASTER, IS_SLAVE, IS_RECEIVER, BUS_BUSY} = {seed[0], seed[1] & ~seed[0], seed[3:2]};
            rdb(8'h04);
            cmp_b(v1[0], exp_dir(IS_MASTER, IS_SLAVE, IS_RECEIVER));
            cmp_b(v1[3], BUS_BUSY);
        end
        // Own transaction hides foreign activity until stop
        {BUS_BUSY, own_st, nack_p} = 3'h7;
        idle(1);
        {own_st, nack_p} = 2'h0;
        idle(1);
        rdb(8'h04);
        cmp_w(v1 & 32'he, 32'h6);
        pulse(5);
        rdb(8'h04);
        cmp_w(v1 & 32'he, 32'ha);
        wr(8'h00, 32'h2);
        pulse(5);
        cmp_b(IRQ, 1'b0);
        rdb(8'h04);
        cmp_w(v1 & M, 32'h80);
        pulse(7);
        wr(8'h00, 32'h3);
        idle(1);
        rdb(8'h00);
        cmp_w(v1, 32'h2);
        rdb(8'h04);
        cmp_w(v1 & M, 32'h0);
        seed = xs(seed);
        {g, d} = {seed[7:4], 18'h3 + seed[3:0]};
        wr(8'h14, {18'h0, g, 10'h0});
        idle(1);
        cmp_w({28'h0, GLITCH_LEN}, {28'h0, g});
        wr(8'h08, {14'h0, d});
        rdb(8'h08);
        cmp_w(v1, {14'h0, d});
        idle(60);
        cmp_b(SCL_DRIVE, 1'b1);
        wr(8'h00, 32'h6);
        while (SCL_DRIVE !== 1'b0)
            @(negedge CLK);
        for (n = 0; SCL_DRIVE !== 1'b1; n = n + 1)
            @(negedge CLK);
        for (n = n; SCL_DRIVE !== 1'b0; n = n + 1)
            @(negedge CLK);
        cmp_w(n, 2 * (d + 2) + g);
        wr(8'h00, 32'h0);
        idle(4);
        end_sim;
    end
endmodule
